// ==== include/cspmc_regs.vh ====
// constants for the cyclic setpoint mode control block
`ifndef CSPMC_REGS_VH
`define CSPMC_REGS_VH
`define CSPMC_MODE_IP        8'h07
`define CSPMC_MODE_CSP       8'h08
`define CSPMC_MODE_CSV       8'h09
`define CSPMC_CMD_ENABLE_BIT 4
`define CSPMC_CMD_STOP_BIT   8
`define CSPMC_ST_SYNC_BIT    8
`define CSPMC_ST_REACH_BIT   10
`define CSPMC_ST_LIMIT_BIT   11
`define CSPMC_ST_FOLLOW_BIT  12
`define CSPMC_ST_FERR_BIT    13
`define CSPMC_CMD_RESET      16'h0000
`define CSPMC_STATE_RESET    16'h0000
`define CSPMC_CLK_MHZ        200
`define CSPMC_BASE_MS        1
`define CSPMC_TICKS_PER_MS   (`CSPMC_CLK_MHZ * 1000 * `CSPMC_BASE_MS)
`define CSPMC_EXP_MS         8'hFD
`define CSPMC_SYNC_MISS      4
`endif

// ==== core/cspmc_core.v ====
// mode and status logic for interpolated and cyclic synchronous setpoint modes
// Behaviour
// - mode value 7 selects interpolated position
// - start sync once network state operational
// - interpolation active only with command bit 4
// - stop bit halts; edges pick brake/ramp
// - status 10 reached or stopped at zero speed
// - status 11 when demand outside travel bounds
// - status 12 while interpolation active
// - linear path to single interpolation target
// - period setting is milliseconds between targets
// - target writes accepted only when buffer enabled
// - mode value 8 selects cyclic position
// - cyclic targets absolute, no start bit needed
// - status 8 shows fieldbus sync
// - status 12 shows setpoint in use
// - following error after band timeout, status 13
// - cycle = period times 1 ms base
// - commanded position confined to travel bounds
// - quick stop uses its deceleration and option
// - mode value 9 follows cyclic velocity
// - limit switch checking stays active
`timescale 1ns/1ps
`include "cspmc_regs.vh"
module cspmc_core (
  input  wire               clk_in,
  input  wire               sys_rst_in,
  input  wire               clk_en_in,
  input  wire        [7:0]  operating_mode_select_in,
  input  wire               cmd_write_in,
  input  wire        [15:0] cmd_data_in,
  input  wire               net_operational_in,
  input  wire               sync_pin_in,
  input  wire        [15:0] period_count_in,
  input  wire        [7:0]  period_exp_in,
  input  wire               buffer_enable_in,
  input  wire               target_write_in,
  input  wire signed [31:0] target_pos_in,
  input  wire signed [31:0] target_vel_in,
  input  wire signed [31:0] actual_pos_in,
  input  wire signed [31:0] actual_vel_in,
  input  wire signed [31:0] limit_min_in,
  input  wire signed [31:0] limit_max_in,
  input  wire        [31:0] ferr_window_in,
  input  wire        [15:0] ferr_timeout_ms_in,
  input  wire               limit_switch_in,
  input  wire               quick_stop_in,
  input  wire        [15:0] halt_option_in,
  input  wire        [15:0] qstop_option_in,
  input  wire        [31:0] qstop_decel_in,
  output reg         [15:0] drive_command_word_out,
  output reg         [15:0] drive_state_word_out,
  output reg  signed [31:0] demand_pos_out,
  output reg  signed [31:0] demand_vel_out,
  output reg                ip_mode_out,
  output reg                csp_mode_out,
  output reg                csv_mode_out,
  output reg                brake_out,
  output reg                ramp_start_out,
  output reg         [31:0] brake_decel_sel_out,
  output reg         [15:0] brake_action_out,
  output reg                ferr_fault_out,
  output reg                limit_stop_out
);
  localparam [31:0] TICKS_MS = `CSPMC_TICKS_PER_MS;
  localparam [2:0]  MISS_MAX = `CSPMC_SYNC_MISS;
  // three-stage sampler on the external sync pin
  reg               sync_s1_reg;
  reg               sync_s2_reg;
  reg               sync_s3_reg;
  reg               sync_lvl_reg;

  // timebase and sync lock
  reg        [31:0] ms_cnt_reg;
  reg        [15:0] cyc_ms_reg;
  reg        [2:0]  miss_reg;
  reg               synced_reg;

  // command tracking and following error timer
  reg        [15:0] cmd_last_reg;
  reg               stop_prev_reg;
  reg               stop_mem_reg;
  reg        [15:0] ferr_ms_reg;

  // interpolation path
  reg signed [31:0] ip_target_reg;
  reg signed [31:0] ip_start_reg;
  reg signed [31:0] ip_step_reg;
  // combinational results
  reg signed [31:0] raw_pos;
  reg signed [31:0] clip_pos;
  reg        [31:0] pos_err;
  reg        [15:0] state_next;
  reg        [31:0] decel_next;
  reg        [15:0] action_next;
  // mode decode
  wire is_ip  = operating_mode_select_in == `CSPMC_MODE_IP;
  wire is_csp = operating_mode_select_in == `CSPMC_MODE_CSP;
  wire is_csv = operating_mode_select_in == `CSPMC_MODE_CSV;
  wire cyclic = is_csp | is_csv;
  // command word as it stands this cycle, a write taking effect at once
  wire [15:0] cmd_now = cmd_write_in ? cmd_data_in : cmd_last_reg;
  wire stop_now = cmd_now[`CSPMC_CMD_STOP_BIT];
  wire halt_rise = stop_now & ~stop_prev_reg;
  wire ip_active = is_ip & cmd_now[`CSPMC_CMD_ENABLE_BIT] & ~stop_now;
  // sync edge seen only once second and third stage agree
  wire sync_edge = (sync_s2_reg == sync_s3_reg) & sync_s3_reg & ~sync_lvl_reg;
  // millisecond tick and cycle end
  wire ms_tick = ms_cnt_reg == TICKS_MS - 32'h0000_0001;
  // only the millisecond base is supported; other exponents never cycle
  wire exp_ok = period_exp_in == `CSPMC_EXP_MS;
  wire cyc_end = ms_tick & exp_ok & (cyc_ms_reg + 16'h0001 >= period_count_in);
  // the cyclic setpoint is used only while locked and not quick stopping
  wire follow = cyclic & synced_reg & ~quick_stop_in;
  // following error once the counted ms exceed the timeout
  wire ferr_hit = is_csp & (ferr_ms_reg > ferr_timeout_ms_in);

  // linear interpolation and bound clamp, combinational
  always @* begin
    raw_pos = actual_pos_in;
    if (is_ip)
      raw_pos = ip_active ? ip_start_reg + ip_step_reg : demand_pos_out;
    else if (is_csp)
      raw_pos = follow ? target_pos_in : demand_pos_out;
    clip_pos = raw_pos;
    if (raw_pos < limit_min_in)
      clip_pos = limit_min_in;
    else if (raw_pos > limit_max_in)
      clip_pos = limit_max_in;
  end

  // distance between actual and demand, for the following error band
  always @* begin
    pos_err = (actual_pos_in > demand_pos_out) ? actual_pos_in - demand_pos_out
                                               : demand_pos_out - actual_pos_in;
  end

  // brake selection: quick stop first, then a fresh halt edge,
  // otherwise the last choice is held so the drive keeps braking the same way
  always @* begin
    decel_next  = brake_decel_sel_out;
    action_next = brake_action_out;
    if (quick_stop_in) begin
      decel_next  = qstop_decel_in;
      action_next = qstop_option_in;
    end else if (halt_rise) begin
      decel_next  = 32'h0000_0000;
      action_next = halt_option_in;
    end
  end

  // three-flop sampler on the sync pin; the level moves once two stages agree
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sync_s1_reg  <= 1'b0;
      sync_s2_reg  <= 1'b0;
      sync_s3_reg  <= 1'b0;
      sync_lvl_reg <= 1'b0;
    end else if (clk_en_in) begin
      sync_s1_reg <= sync_pin_in;
      sync_s2_reg <= sync_s1_reg;
      sync_s3_reg <= sync_s2_reg;
      if (sync_s2_reg == sync_s3_reg)
        sync_lvl_reg <= sync_s3_reg;
    end
  end

  // free-running millisecond divider of the core clock
  // a full ms is 200000 clocks, so cycle-end events need long runs to reach
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ms_cnt_reg <= 32'h0000_0000;
    end else if (clk_en_in) begin
      ms_cnt_reg <= ms_tick ? 32'h0000_0000 : ms_cnt_reg + 32'h0000_0001;
    end
  end

  // whole ms counted inside the current setpoint cycle
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cyc_ms_reg <= 16'h0000;
    end else if (clk_en_in) begin
      if (cyc_end)
        cyc_ms_reg <= 16'h0000;
      else if (ms_tick)
        cyc_ms_reg <= cyc_ms_reg + 16'h0001;
    end
  end

  // lock on sync once operational; drop after missed cycles
  // loss is only judged at cycle ends, so it is reported late
  // any sync edge clears the miss count
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      miss_reg   <= 3'h0;
      synced_reg <= 1'b0;
    end else if (clk_en_in) begin
      if (!net_operational_in) begin
        synced_reg <= 1'b0;
        miss_reg   <= 3'h0;
      end else if (sync_edge) begin
        synced_reg <= 1'b1;
        miss_reg   <= 3'h0;
      end else if (cyc_end) begin
        if (miss_reg == MISS_MAX)
          synced_reg <= 1'b0;
        else
          miss_reg <= miss_reg + 3'h1;
      end
    end
  end

  // command word capture; a write takes effect in the cycle it is seen
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cmd_last_reg           <= `CSPMC_CMD_RESET;
      drive_command_word_out <= `CSPMC_CMD_RESET;
      stop_prev_reg          <= 1'b0;
      stop_mem_reg           <= 1'b0;
    end else if (clk_en_in) begin
      cmd_last_reg           <= cmd_now;
      drive_command_word_out <= cmd_now;
      // stop edges compare against the previous cycle's word
      stop_prev_reg          <= stop_now;
      // reached bit looks at the stop bit of the last write only
      if (cmd_write_in)
        stop_mem_reg <= stop_now;
    end
  end

  // mode flags follow the selector one cycle later
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ip_mode_out  <= 1'b0;
      csp_mode_out <= 1'b0;
      csv_mode_out <= 1'b0;
    end else if (clk_en_in) begin
      ip_mode_out  <= is_ip;
      csp_mode_out <= is_csp;
      csv_mode_out <= is_csv;
    end
  end

  // halt edges: rising brakes, falling restarts ramp
  // quick stop takes precedence so its deceleration is never masked
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      brake_out           <= 1'b0;
      ramp_start_out      <= 1'b0;
      brake_decel_sel_out <= 32'h0000_0000;
      brake_action_out    <= 16'h0000;
      limit_stop_out      <= 1'b0;
    end else if (clk_en_in) begin
      ramp_start_out      <= stop_prev_reg & ~stop_now;
      brake_out           <= stop_now | quick_stop_in | limit_switch_in;
      brake_decel_sel_out <= decel_next;
      brake_action_out    <= action_next;
      limit_stop_out      <= limit_switch_in;
    end
  end

  // target entry locked unless buffer enabled
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ip_target_reg <= 32'h0000_0000;
      ip_start_reg  <= 32'h0000_0000;
      ip_step_reg   <= 32'h0000_0000;
    end else if (clk_en_in) begin
      // a new target restarts the path from where the demand stands now
      if (target_write_in & buffer_enable_in & is_ip) begin
        ip_target_reg <= target_pos_in;
        ip_start_reg  <= demand_pos_out;
        ip_step_reg   <= 32'h0000_0000;
      end else if (ip_active & ms_tick & exp_ok & (period_count_in != 16'h0000)) begin
        // per-ms step of a linear path; truncating division leaves a small
        // shortfall that the jump to the target at cycle end absorbs
        ip_step_reg <= ip_step_reg + (ip_target_reg - ip_start_reg)
                       / $signed({16'h0000, period_count_in});
        if (cyc_end) begin
          ip_start_reg <= ip_target_reg;
          ip_step_reg  <= 32'h0000_0000;
        end
      end
    end
  end

  // demand outputs; velocity zero unless the cyclic setpoint is in use in velocity mode
  // the clamp keeps the commanded position inside the travel bounds
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      demand_pos_out <= 32'h0000_0000;
      demand_vel_out <= 32'h0000_0000;
    end else if (clk_en_in) begin
      demand_pos_out <= clip_pos;
      demand_vel_out <= (is_csv & follow) ? target_vel_in : 32'h0000_0000;
    end
  end

  // following error timer counts whole ms outside the band
  // saturates so a long excursion cannot wrap back to no error
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ferr_ms_reg    <= 16'h0000;
      ferr_fault_out <= 1'b0;
    end else if (clk_en_in) begin
      if (!(is_csp & synced_reg) || pos_err <= ferr_window_in)
        ferr_ms_reg <= 16'h0000;
      else if (ms_tick && ferr_ms_reg != 16'hFFFF)
        ferr_ms_reg <= ferr_ms_reg + 16'h0001;
      ferr_fault_out <= ferr_hit;
    end
  end

  // next state word; bits unused by the current mode read as zero
  // reached uses the stop bit of the last write, not the live one
  always @* begin
    state_next = `CSPMC_STATE_RESET;
    state_next[`CSPMC_ST_SYNC_BIT] = cyclic & synced_reg;
    state_next[`CSPMC_ST_LIMIT_BIT] =
      (raw_pos < limit_min_in) | (raw_pos > limit_max_in);
    if (is_ip) begin
      if (stop_mem_reg)
        state_next[`CSPMC_ST_REACH_BIT] = actual_vel_in == 32'h0000_0000;
      else
        state_next[`CSPMC_ST_REACH_BIT] = actual_pos_in == ip_target_reg;
      state_next[`CSPMC_ST_FOLLOW_BIT] = ip_active;
    end else begin
      state_next[`CSPMC_ST_FOLLOW_BIT] = follow;
    end
    state_next[`CSPMC_ST_FERR_BIT] = ferr_hit;
  end

  // status register; holds while the clock enable is low
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in)
      drive_state_word_out <= `CSPMC_STATE_RESET;
    else if (clk_en_in)
      drive_state_word_out <= state_next;
  end
endmodule

// ==== bench/cspmc_host_model.sv ====
// host-side model: periodic sync pulses and one setpoint write per sync cycle
`timescale 1ns/1ps
module cspmc_host_model #(parameter int PERIOD = 40) (
  input  wire logic clk_in,
  input  wire logic run_in,
  output logic      sync_out = 1'b0,
  output logic      write_out = 1'b0
);
  int cnt = 0;
  // fixed spacing, so the drive never sees a jittered sync
  always @(posedge clk_in) begin
    cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
    sync_out <= run_in && (cnt < 4);
    write_out <= run_in && (cnt == 5);
  end
endmodule

// ==== bench/cspmc_checker.sv ====
// port assertions for the setpoint mode block
`timescale 1ns/1ps
module cspmc_checker (
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic        clk_en_in,
  input wire logic [7:0]  operating_mode_select_in,
  input wire logic        cmd_write_in,
  input wire logic [15:0] cmd_data_in,
  input wire logic [15:0] drive_command_word_out,
  input wire logic [15:0] drive_state_word_out,
  input wire logic        ip_mode_out,
  input wire logic        csp_mode_out,
  input wire logic        brake_out,
  input wire logic        ramp_start_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // halt released by a write while the latched word still holds it
  sequence s_rel; clk_en_in && cmd_write_in && !cmd_data_in[8] && drive_command_word_out[8]; endsequence
  sequence s_pulse; ramp_start_out ##1 !ramp_start_out; endsequence
  mode_ip_a: assert property (
    clk_en_in && operating_mode_select_in == 8'h07 |=> ip_mode_out) else $error("ip flag");
  mode_csp_a: assert property (
    clk_en_in && operating_mode_select_in == 8'h08 |=> csp_mode_out) else $error("csp flag");
  cmd_latch_a: assert property (
    clk_en_in && cmd_write_in |=> drive_command_word_out == $past(cmd_data_in)) else $error("cmd");
  halt_brake_a: assert property (
    clk_en_in && cmd_write_in && cmd_data_in[8] |=> brake_out) else $error("brake");
  halt_release_a: assert property (s_rel |=> s_pulse) else $error("ramp pulse");
  interp_on_a: assert property (
    clk_en_in && cmd_write_in && cmd_data_in[4] && !cmd_data_in[8]
    && operating_mode_select_in == 8'h07 |=> drive_state_word_out[12]) else $error("ip on");
  interp_gate_a: assert property (
    ip_mode_out && drive_state_word_out[12] |-> drive_command_word_out[4]
    && !drive_command_word_out[8]) else $error("ip gate");
  reset_clear_a: assert property (
    $fell(sys_rst_in) |-> drive_state_word_out == 16'h0000 && drive_command_word_out == 16'h0000)
    else $error("reset");
endmodule
bind cspmc_core cspmc_checker i_chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .clk_en_in(clk_en_in), .operating_mode_select_in(operating_mode_select_in),
  .cmd_write_in(cmd_write_in), .cmd_data_in(cmd_data_in), .ip_mode_out(ip_mode_out),
  .drive_command_word_out(drive_command_word_out), .drive_state_word_out(drive_state_word_out),
  .csp_mode_out(csp_mode_out), .brake_out(brake_out), .ramp_start_out(ramp_start_out));

// ==== bench/cyclic_setpoint_mode_control_tb.sv ====
// self-checking bench for the cyclic setpoint mode block
`timescale 1ns/1ps
`define CHK(n, e, a) begin comparisons++; if ((e) !== (a)) begin n_fail++; \
  $display("unexpected %s exp %h got %h", n, e, a); end end
module cyclic_setpoint_mode_control_tb;
  logic clk_in = 1'b0, sys_rst_in = 1'b1, cmd_write_in = 1'b0, net_operational_in = 1'b0;
  logic buffer_enable_in = 1'b0, limit_switch_in = 1'b0, quick_stop_in = 1'b0, run = 1'b0;
  logic        [7:0]  operating_mode_select_in = 8'h00;
  logic        [15:0] cmd_data_in = 16'h0000, halt_option_in = 16'h0000, qstop_option_in = 16'h0000;
  logic signed [31:0] target_pos_in = '0, target_vel_in = '0, actual_pos_in = '0, actual_vel_in = '0;
  logic signed [31:0] limit_min_in = 32'shFFFFFC18, limit_max_in = 32'sh000003E8;
  logic        [31:0] qstop_decel_in = 32'h00000000, ex;
  wire         [15:0] drive_command_word_out, drive_state_word_out, brake_action_out;
  wire  signed [31:0] demand_pos_out, demand_vel_out;
  wire         [31:0] brake_decel_sel_out;
  wire ip_mode_out, csp_mode_out, csv_mode_out, brake_out, sync_w, twr, ferr_w, lim_w;
  logic clk_en = 1'b1;
  int n_fail = 0, comparisons = 0;
  string nq[$], nm;
  logic [31:0] eq[$];
  event seen;
  always #2.5 clk_in = ~clk_in;
  cspmc_host_model #(.PERIOD(40)) i_host (.clk_in, .run_in(run), .sync_out(sync_w), .write_out(twr));
  cspmc_core i_dut (.clk_in, .sys_rst_in, .clk_en_in(clk_en), .operating_mode_select_in,
    .cmd_write_in, .cmd_data_in, .net_operational_in, .sync_pin_in(sync_w),
    .period_count_in(16'h0001), .period_exp_in(8'hFD), .buffer_enable_in,
    .target_write_in(twr), .target_pos_in, .target_vel_in, .actual_pos_in, .actual_vel_in,
    .limit_min_in, .limit_max_in, .ferr_window_in(32'h00000100), .ferr_timeout_ms_in(16'h0001),
    .limit_switch_in, .quick_stop_in, .halt_option_in, .qstop_option_in, .qstop_decel_in,
    .drive_command_word_out, .drive_state_word_out, .demand_pos_out, .demand_vel_out,
    .ip_mode_out, .csp_mode_out, .csv_mode_out, .brake_out, .ramp_start_out(),
    .brake_decel_sel_out, .brake_action_out, .ferr_fault_out(ferr_w), .limit_stop_out(lim_w));
  // oldest note is matched against the output it names
  always @(seen) while (nq.size() > 0) begin
    nm = nq.pop_front();
    ex = eq.pop_front();
    `CHK(nm, ex, got(nm))
  end
  function automatic logic [31:0] got(string n);
    case (n)
      "follow": return 32'(drive_state_word_out[12]);
      "sync": return 32'(drive_state_word_out[8]);
      "modes": return 32'({ip_mode_out, csp_mode_out, csv_mode_out});
      "brake": return 32'(brake_out);
      "action": return 32'(brake_action_out);
      "decel": return brake_decel_sel_out;
      "dpos": return demand_pos_out;
      "reach": return 32'(drive_state_word_out[10]);
      "limit": return 32'(drive_state_word_out[11]);
      "ferr": return 32'({ferr_w, drive_state_word_out[13]});
      "lstop": return 32'(lim_w);
      "cmd": return 32'(drive_command_word_out);
      default: return demand_vel_out;
    endcase
  endfunction
  task automatic note(string n, logic [31:0] e);
    nq.push_back(n);
    eq.push_back(e);
  endtask
  // let the edge settle before the watcher looks
  task automatic fin(string s);
    #1;
    -> seen;
    #1;
    $display("test %s done", s);
  endtask
  task automatic wr_cmd(logic [15:0] d);
    @(posedge clk_in);
    cmd_write_in <= 1'b1;
    cmd_data_in <= d;
    @(posedge clk_in);
    cmd_write_in <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    int k;
    void'($urandom(81904));
    repeat (3) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    halt_option_in <= 16'($urandom());
    qstop_option_in <= 16'($urandom());
    qstop_decel_in <= $urandom();
    actual_pos_in <= 32'($urandom_range(200));
    operating_mode_select_in <= 8'h07;
    wr_cmd(16'h0010);
    note("follow", 32'h1);
    note("modes", 32'h4);
    note("reach", 32'(actual_pos_in == 32'sh0));
    fin("interp");
    wr_cmd(16'h0110);
    note("follow", 32'h0);
    note("brake", 32'h1);
    note("action", 32'(halt_option_in));
    note("reach", 32'h1);
    fin("halt");
    @(posedge clk_in);
    quick_stop_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    note("action", 32'(qstop_option_in));
    note("decel", qstop_decel_in);
    fin("qstop");
    @(posedge clk_in);
    quick_stop_in <= 1'b0;
    wr_cmd(16'h0000);
    note("brake", 32'h0);
    fin("release");
    @(posedge clk_in);
    limit_switch_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    note("lstop", 32'h1);
    note("brake", 32'h1);
    fin("limit");
    @(posedge clk_in);
    operating_mode_select_in <= 8'h08;
    limit_switch_in <= 1'b0;
    target_pos_in <= limit_max_in + 32'($urandom_range(50, 1));
    run <= 1'b1;
    repeat (100) @(posedge clk_in);
    note("sync", 32'h0);
    fin("offline");
    @(posedge clk_in);
    net_operational_in <= 1'b1;
    for (k = 0; k < 300 && drive_state_word_out[8] !== 1'b1; k++) @(posedge clk_in);
    if (k == 300) begin n_fail++; close_out(); end
    repeat (50) @(posedge clk_in);
    note("sync", 32'h1);
    note("follow", 32'h1);
    note("modes", 32'h2);
    note("dpos", limit_max_in);
    note("limit", 32'h1);
    note("ferr", 32'h0);
    fin("csp");
    @(posedge clk_in);
    operating_mode_select_in <= 8'h09;
    target_vel_in <= 32'($urandom_range(5000, 1));
    repeat (50) @(posedge clk_in);
    note("dvel", target_vel_in);
    note("modes", 32'h1);
    note("limit", 32'h0);
    fin("csv");
    @(posedge clk_in);
    clk_en <= 1'b0;
    wr_cmd(16'h0110);
    note("cmd", 32'h0);
    note("brake", 32'h0);
    fin("freeze");
    @(posedge clk_in);
    clk_en <= 1'b1;
    close_out();
  end
endmodule
